//--- inc/esp_defs.svh
// Attribute indices, reset values and timing constants for the encoder position block
`ifndef ESP_DEFS_SVH
`define ESP_DEFS_SVH

// Attribute indices on the explicit-message attribute port
`define ESP_ATTR_TOTAL_RANGE  8'h11
`define ESP_ATTR_PRESET       8'h13
`define ESP_ATTR_SPEED        8'h18
`define ESP_ATTR_SPEED_UNIT   8'h19
`define ESP_ATTR_RUN_STATE    8'h29

// Run state field positions
`define ESP_RUN_DIR_BIT       0
`define ESP_RUN_SCALE_BIT     1

// Warning field position
`define ESP_WARN_PARAM_BIT    13

// Reset values and limits
`define ESP_PRESET_RST        32'h0000_0000
`define ESP_UNIT_RST          16'h1F04
`define ESP_UNIT_MIN          16'h1F04
`define ESP_UNIT_MAX          16'h1F10
`define ESP_RANGE_MIN         32'h0000_0001

// Timing: velocity period and clock rate
`define ESP_VEL_PERIOD_MS     100
`define ESP_CLK_KHZ           250000

`endif

//--- inc/esp_pkg.sv
// Types shared by the encoder position block
package esp_pkg;

  // Velocity unit codes
  typedef enum logic [15:0] {
    ESP_CPS  = 16'h1F04,
    ESP_CPMS = 16'h1F05,
    ESP_CPM  = 16'h1F07,
    ESP_RPS  = 16'h1F0E,
    ESP_RPM  = 16'h1F0F,
    ESP_RPH  = 16'h1F10
  } esp_unit_type;

endpackage

//--- rtl/esp_core.sv
// Encoder position post-processing: scaling, preset/offset, velocity, run state
`timescale 1ns/1ps
`include "esp_defs.svh"

module esp_core
  import esp_pkg::*;
#(
  parameter int unsigned POS_W      = 30,
  parameter int unsigned HW_CPT     = 65536,
  parameter int unsigned HW_TURNS   = 16384,
  parameter int unsigned VEL_CYCLES = `ESP_VEL_PERIOD_MS * `ESP_CLK_KHZ
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Sensor position, hardware counts, clockwise sense
  input  wire logic [POS_W-1:0]  shaft_pos_i,
  // Configuration held outside this block
  input  wire logic              scaling_en_i,
  input  wire logic              count_ccw_i,
  input  wire logic [31:0]       units_per_turn_i,
  input  wire logic              preset_cmd_i,
  // Attribute access port
  input  wire logic              attr_valid_i,
  input  wire logic              attr_write_i,
  input  wire logic [7:0]        attr_id_i,
  input  wire logic [31:0]       attr_wdata_i,
  output logic                   attr_ack_o,
  output logic                   attr_err_o,
  output logic [31:0]            attr_rdata_o,
  // Position and warnings
  output logic [31:0]            position_o,
  output logic [15:0]            warnings_o,
  output logic                   warn_flag_o
);

  localparam logic [31:0] HW_TOTAL = 32'(HW_CPT * HW_TURNS);
  localparam logic [31:0] HW_CPT_W = 32'(HW_CPT);

  logic [31:0]        custom_total;
  logic [31:0]        preset;
  logic [31:0]        offset;
  logic [15:0]        unit_sel;
  logic [31:0]        speed;
  logic [31:0]        next_speed;
  logic               count_falling;
  logic [POS_W-1:0]   raw_prev;
  logic [POS_W-1:0]   vel_base;
  logic [31:0]        tick_cnt;
  logic               vel_tick;
  logic [31:0]        cpt_act;
  logic [31:0]        range_act;
  logic [POS_W-1:0]   raw_sense;
  logic [31:0]        read_pos;
  logic [31:0]        next_position;
  logic               param_bad;
  logic signed [POS_W-1:0] step_delta;
  logic signed [POS_W-1:0] vel_delta;
  logic               wr_hit;
  logic               wr_ok;

  // Count sense folds shaft rotation into counting direction
  assign raw_sense = count_ccw_i ? POS_W'(HW_TOTAL - 32'd1 - 32'(shaft_pos_i)) : shaft_pos_i;

  // Out-of-range custom counts per turn fall back to the hardware value
  assign cpt_act   = (units_per_turn_i > HW_CPT_W || units_per_turn_i == 32'h0)
                     ? HW_CPT_W : units_per_turn_i;

  // Active range selects custom values only under scaling
  assign range_act = scaling_en_i ? custom_total : HW_TOTAL;

  // Scaled read position, bounded by the custom range
  // Division is by a constant; the modulo by a register costs area but keeps any range legal
  always_comb begin
    logic [63:0] prod;
    prod = 64'(raw_sense) * 64'(cpt_act) / 64'(HW_CPT_W);
    if (scaling_en_i) begin
      read_pos = 32'(prod % 64'(custom_total));
    end else begin
      read_pos = 32'(raw_sense);
    end
  end

  // Read position plus preset minus offset, wrapped into the active range
  always_comb begin
    logic [33:0] sum;
    logic [33:0] diff;
    sum  = 34'(read_pos) + 34'(preset);
    diff = sum - 34'(offset);
    if (sum < 34'(offset)) begin
      diff = sum + 34'(range_act) - 34'(offset % range_act); // Offset may exceed a shrunk range
    end
    next_position = 32'(diff % 34'(range_act));
  end

  // Tolerance check is a live level, so it clears itself
  assign param_bad = scaling_en_i && (custom_total < cpt_act);

  // Transmitted position and warning outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      position_o  <= 32'h0000_0000;
      warnings_o  <= 16'h0000;
      warn_flag_o <= 1'b0;
    end else begin
      position_o  <= next_position;
      warnings_o  <= 16'(param_bad) << `ESP_WARN_PARAM_BIT;
      warn_flag_o <= param_bad;
    end
  end

  // Write decode
  assign wr_hit = attr_valid_i && attr_write_i;

  always_comb begin
    wr_ok = 1'b0;
    case (attr_id_i)
      `ESP_ATTR_TOTAL_RANGE: wr_ok = attr_wdata_i >= `ESP_RANGE_MIN &&
                                     attr_wdata_i <= HW_TOTAL;
      `ESP_ATTR_PRESET:      wr_ok = attr_wdata_i < HW_TOTAL;
      `ESP_ATTR_SPEED_UNIT:  begin
        case (attr_wdata_i[15:0])
          ESP_CPS, ESP_CPMS, ESP_CPM, ESP_RPS, ESP_RPM, ESP_RPH:
            wr_ok = attr_wdata_i[31:16] == 16'h0000;
          default: wr_ok = 1'b0;
        endcase
      end
      default:               wr_ok = 1'b0;
    endcase
  end

  // Custom total range, full hardware range after reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      custom_total <= HW_TOTAL;
    end else if (wr_hit && wr_ok && attr_id_i == `ESP_ATTR_TOTAL_RANGE) begin
      custom_total <= attr_wdata_i;
    end
  end

  // Preset target and offset; the target applies at the write's shaft position
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      preset <= `ESP_PRESET_RST;
      offset <= `ESP_PRESET_RST;
    end else if (wr_hit && wr_ok && attr_id_i == `ESP_ATTR_PRESET) begin
      preset <= attr_wdata_i;
      offset <= read_pos;
    end else if (preset_cmd_i) begin
      offset <= read_pos;
    end
  end

  // Velocity unit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      unit_sel <= `ESP_UNIT_RST;
    end else if (wr_hit && wr_ok && attr_id_i == `ESP_ATTR_SPEED_UNIT) begin
      unit_sel <= attr_wdata_i[15:0];
    end
  end

  // Live counting direction; wrap is absorbed because the raw span is a power of two
  assign step_delta = $signed(raw_sense - raw_prev);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      raw_prev      <= raw_sense; // No false step right after reset
      count_falling <= 1'b0;
    end else begin
      raw_prev <= raw_sense;
      if (step_delta != '0) begin
        count_falling <= step_delta < 0;
      end
    end
  end

  // Velocity period divider
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_cnt <= 32'h0000_0000;
      vel_tick <= 1'b0;
    end else if (tick_cnt == VEL_CYCLES - 1) begin
      tick_cnt <= 32'h0000_0000;
      vel_tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 32'd1;
      vel_tick <= 1'b0;
    end
  end

  // Counts moved per period, in hardware counts
  assign vel_delta = $signed(raw_sense - vel_base);

  // Velocity in the selected unit; count units divide before the multiplier, revolution units multiply before dividing
  always_comb begin
    logic signed [63:0] num;
    logic signed [63:0] den;
    num = 64'(vel_delta) * $signed({32'h0, scaling_en_i ? cpt_act : HW_CPT_W});
    den = $signed({32'h0, HW_CPT_W});
    case (unit_sel)
      ESP_CPS:  num = (num / den) * 64'sd10;
      ESP_CPMS: num = num / (den * 64'sd100);
      ESP_CPM:  num = (num / den) * 64'sd600;
      ESP_RPS:  num = (64'(vel_delta) * 64'sd10) / den;
      ESP_RPM:  num = (64'(vel_delta) * 64'sd600) / den;
      ESP_RPH:  num = (64'(vel_delta) * 64'sd36000) / den;
      default:  num = 64'sd0;
    endcase
    next_speed = 32'(num);
  end

  // Speed and period base load once a period; base starts at the live position
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vel_base <= raw_sense;
      speed    <= 32'h0000_0000;
    end else if (vel_tick) begin
      vel_base <= raw_sense;
      speed    <= next_speed;
    end
  end

  // Attribute port: answer one cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      attr_ack_o   <= 1'b0;
      attr_err_o   <= 1'b0;
      attr_rdata_o <= 32'h0000_0000;
    end else begin
      attr_ack_o   <= attr_valid_i;
      attr_err_o   <= 1'b0;
      attr_rdata_o <= 32'h0000_0000;
      if (attr_valid_i && attr_write_i) begin
        attr_err_o <= !wr_ok;
      end else if (attr_valid_i) begin
        case (attr_id_i)
          `ESP_ATTR_TOTAL_RANGE: attr_rdata_o <= custom_total;
          `ESP_ATTR_PRESET:      attr_rdata_o <= preset;
          `ESP_ATTR_SPEED:       attr_rdata_o <= speed;
          `ESP_ATTR_SPEED_UNIT:  attr_rdata_o <= {16'h0000, unit_sel};
          `ESP_ATTR_RUN_STATE:   attr_rdata_o <= {30'h0, scaling_en_i, count_falling};
          default:               attr_err_o   <= 1'b1;
        endcase
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_range_refuse: assert property (
    (wr_hit && attr_id_i == `ESP_ATTR_TOTAL_RANGE && attr_wdata_i == 32'h0)
      |=> attr_ack_o && attr_err_o && $stable(custom_total))
    else $error("zero total range was accepted");

  chk_range_accept: assert property (
    (wr_hit && attr_id_i == `ESP_ATTR_TOTAL_RANGE && attr_wdata_i <= HW_TOTAL &&
     attr_wdata_i != 32'h0) |=> custom_total == $past(attr_wdata_i) && !attr_err_o)
    else $error("legal total range not stored");

  chk_preset_capture: assert property (
    (wr_hit && attr_id_i == `ESP_ATTR_PRESET && attr_wdata_i < HW_TOTAL)
      |=> offset == $past(read_pos) && preset == $past(attr_wdata_i))
    else $error("preset write did not capture offset");

  chk_preset_cmd: assert property (
    (preset_cmd_i && !(wr_hit && attr_id_i == `ESP_ATTR_PRESET))
      |=> offset == $past(read_pos) && $stable(preset))
    else $error("preset command misbehaved");

  chk_preset_refuse: assert property (
    (wr_hit && attr_id_i == `ESP_ATTR_PRESET && attr_wdata_i >= HW_TOTAL)
      |=> attr_err_o && $stable(preset))
    else $error("preset above maximum accepted");

  chk_preset_value: assert property (
    (wr_hit && attr_id_i == `ESP_ATTR_PRESET && attr_wdata_i < range_act)
      ##1 ($stable(shaft_pos_i) && $stable(range_act) && $stable(count_ccw_i)
           && !preset_cmd_i && !wr_hit)
      |=> position_o == preset)
    else $error("position not equal to preset after preset");

  chk_warn_level: assert property (
    param_bad |=> warnings_o[`ESP_WARN_PARAM_BIT] && warn_flag_o)
    else $error("parameter warning missing");

  chk_warn_clear: assert property (
    (!param_bad ##1 !param_bad) |-> !warn_flag_o && warnings_o == 16'h0)
    else $error("warning not cleared");

  chk_unit_refuse: assert property (
    (wr_hit && attr_id_i == `ESP_ATTR_SPEED_UNIT && attr_wdata_i > 32'(`ESP_UNIT_MAX))
      |=> attr_err_o && $stable(unit_sel))
    else $error("illegal velocity unit accepted");

  chk_pos_range: assert property (
    $stable(range_act) |=> position_o < $past(range_act))
    else $error("position outside active range");

  chk_status_scale: assert property (
    (attr_valid_i && !attr_write_i && attr_id_i == `ESP_ATTR_RUN_STATE)
      |=> attr_rdata_o[`ESP_RUN_SCALE_BIT] == $past(scaling_en_i)
          && attr_rdata_o[`ESP_RUN_DIR_BIT] == $past(count_falling))
    else $error("run state readback wrong");

  chk_vel_period: assert property (
    vel_tick |=> tick_cnt == 32'd1 && !vel_tick)
    else $error("velocity period restarted wrongly");

endmodule // esp_core

//--- testbench/esp_ctrl_model.sv
// Controller model issuing attribute requests to the encoder position block
`timescale 1ns/1ps
`include "esp_defs.svh"
module esp_ctrl_model (
  // Clock
  input  wire logic        clk_i,
  // Request side
  output logic             valid_o,
  output logic             write_o,
  output logic [7:0]       id_o,
  output logic [31:0]      wdata_o,
  // Answer side
  input  wire logic        ack_i,
  input  wire logic        err_i,
  input  wire logic [31:0] rdata_i
);
  // Bus idles with no request pending
  initial begin
    valid_o = 1'b0;
    write_o = 1'b0;
    id_o    = 8'h00;
    wdata_o = 32'h0000_0000;
  end

  // One request; released lines show the inverse so stale values never pass as held
  task automatic xfer(input logic wr, input logic [7:0] id, input logic [31:0] wd,
                      output logic [1:0] st, output logic [31:0] rd);
    @(posedge clk_i);
    valid_o <= 1'b1;
    write_o <= wr;
    id_o    <= id;
    wdata_o <= wd;
    @(posedge clk_i);
    valid_o <= 1'b0;
    write_o <= ~wr;
    id_o    <= ~id;
    wdata_o <= ~wd;
    #1;
    st = {ack_i, err_i};
    rd = rdata_i;
  endtask

  // Range change is always followed by a fresh preset inside the new range
  task automatic new_range(input logic [31:0] rng, input logic [31:0] pre);
    logic [1:0]  st;
    logic [31:0] rd;
    xfer(1'b1, `ESP_ATTR_TOTAL_RANGE, rng, st, rd);
    xfer(1'b1, `ESP_ATTR_PRESET, pre % rng, st, rd);
  endtask
endmodule // esp_ctrl_model

//--- testbench/tb_top.sv
// Self-checking bench for the encoder position block
`timescale 1ns/1ps
`include "esp_defs.svh"
module tb_top;
  import esp_pkg::*;
  // Small hardware range keeps wrap cases short
  localparam int unsigned CPT = 16;
  localparam int unsigned TOT = CPT * 4;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  logic        clk_i, rst_i, scaling_en_i, count_ccw_i, preset_cmd_i;
  logic        attr_valid_i, attr_write_i, attr_ack_o, attr_err_o, warn_flag_o;
  logic        step_on, step_dn;
  logic [5:0]  shaft_pos_i;
  logic [7:0]  attr_id_i;
  logic [15:0] warnings_o;
  logic [31:0] units_per_turn_i, attr_wdata_i, attr_rdata_o, position_o;
  logic [15:0] codes [6] = '{16'h1F04, 16'h1F05, 16'h1F07, 16'h1F0E, 16'h1F0F, 16'h1F10};
  logic [31:0] speeds [6] = '{32'h64, 32'h0, 32'h1770, 32'h6, 32'h177, 32'h57E4};
  int          err_total, checks_done;
  int          cyc = 0;

  esp_core #(.POS_W(6), .HW_CPT(CPT), .HW_TURNS(4), .VEL_CYCLES(50)) i_esp_core (
    .clk_i(clk_i), .rst_i(rst_i), .shaft_pos_i(shaft_pos_i), .scaling_en_i(scaling_en_i),
    .count_ccw_i(count_ccw_i), .units_per_turn_i(units_per_turn_i),
    .preset_cmd_i(preset_cmd_i), .attr_valid_i(attr_valid_i), .attr_write_i(attr_write_i),
    .attr_id_i(attr_id_i), .attr_wdata_i(attr_wdata_i), .attr_ack_o(attr_ack_o),
    .attr_err_o(attr_err_o), .attr_rdata_o(attr_rdata_o), .position_o(position_o),
    .warnings_o(warnings_o), .warn_flag_o(warn_flag_o));

  esp_ctrl_model i_esp_ctrl_model (
    .clk_i(clk_i), .valid_o(attr_valid_i), .write_o(attr_write_i), .id_o(attr_id_i),
    .wdata_o(attr_wdata_i), .ack_i(attr_ack_o), .err_i(attr_err_o), .rdata_i(attr_rdata_o));

  // 250 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // Steady motion, one count every five cycles, so each speed period sees ten counts
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (step_on && (cyc % 5 == 0)) begin
      shaft_pos_i <= step_dn ? shaft_pos_i - 6'h01 : shaft_pos_i + 6'h01;
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rd_chk(input string what, input logic [7:0] id, input logic [31:0] mask,
                        input logic [31:0] exp);
    logic [1:0]  st;
    logic [31:0] d;
    i_esp_ctrl_model.xfer(1'b0, id, 32'h0, st, d);
    check(what, {30'h0, st}, 32'h2);
    check(what, d & mask, exp);
  endtask

  task automatic wr_st(input string what, input logic [7:0] id, input logic [31:0] v,
                       input logic [1:0] exp_st);
    logic [1:0]  st;
    logic [31:0] d;
    i_esp_ctrl_model.xfer(1'b1, id, v, st, d);
    check(what, {30'h0, st}, {30'h0, exp_st});
  endtask

  // Shaft moves only between requests, never during a preset write
  task automatic move(input logic [5:0] v);
    @(posedge clk_i);
    shaft_pos_i <= v;
    repeat (3) @(posedge clk_i);
    #1;
  endtask

  task automatic t_reset();
    rd_chk("range rst", 8'h11, ALL, TOT);
    rd_chk("preset rst", 8'h13, ALL, 32'h0);
    rd_chk("unit rst", 8'h19, ALL, 32'h1F04);
    rd_chk("state rst", 8'h29, ALL, 32'h0);
    check("pos rst", position_o, 32'h0);
  endtask

  // Range limits, unscaled use of the hardware range, read-only and unmapped places
  task automatic t_range();
    wr_st("range zero", 8'h11, 32'h0, 2'b11);
    wr_st("range big", 8'h11, TOT + 1, 2'b11);
    wr_st("range one", 8'h11, 32'h1, 2'b10);
    move(6'h05);
    check("pos unscaled", position_o, 32'h5);
    check("warn unscaled", {16'h0, warnings_o}, 32'h0);
    wr_st("range max", 8'h11, TOT, 2'b10);
    wr_st("speed ro", 8'h18, 32'h0, 2'b11);
    wr_st("state ro", 8'h29, 32'h0, 2'b11);
    wr_st("unmapped", 8'h20, 32'h0, 2'b11);
  endtask

  task automatic t_units();
    for (int i = 0; i < 6; i++) begin
      wr_st("unit wr", 8'h19, {16'h0, codes[i]}, 2'b10);
      rd_chk("unit rd", 8'h19, ALL, {16'h0, codes[i]});
    end
    wr_st("unit below", 8'h19, 32'h1F03, 2'b11);
    wr_st("unit above", 8'h19, 32'h1F11, 2'b11);
    rd_chk("unit kept", 8'h19, ALL, 32'h1F10);
    wr_st("unit back", 8'h19, 32'h1F04, 2'b10);
  endtask

  // Preset while standing still, then wrap past the hardware range
  task automatic t_preset();
    move(6'h0A);
    wr_st("preset wr", 8'h13, 32'h32, 2'b10);
    move(6'h0A);
    check("pos preset", position_o, 32'h32);
    move(6'h0B);
    check("pos step", position_o, 32'h33);
    move(6'h1E);
    check("pos wrap", position_o, 32'h6);
    @(posedge clk_i);
    preset_cmd_i <= 1'b1;
    @(posedge clk_i);
    preset_cmd_i <= 1'b0;
    move(6'h1E);
    check("pos cmd", position_o, 32'h32);
    rd_chk("preset kept", 8'h13, ALL, 32'h32);
    wr_st("preset big", 8'h13, TOT, 2'b11);
    rd_chk("preset held", 8'h13, ALL, 32'h32);
    wr_st("preset top", 8'h13, TOT - 1, 2'b10);
    rd_chk("preset top rd", 8'h13, ALL, TOT - 1);
  endtask

  // Power-of-two custom scaling, then a range below counts per turn
  task automatic t_scale();
    @(posedge clk_i);
    scaling_en_i <= 1'b1;
    units_per_turn_i <= 32'h8;
    i_esp_ctrl_model.new_range(32'h20, 32'h0);
    move(6'h1E);
    check("pos scaled", position_o, 32'h0);
    rd_chk("state scale", 8'h29, 32'h2, 32'h2);
    move(6'h28);
    check("pos ratio", position_o, 32'h5);
    move(6'h02);
    check("pos swrap", position_o, 32'h12);
    wr_st("range low", 8'h11, 32'h4, 2'b10);
    move(6'h02);
    check("warn bit", {16'h0, warnings_o}, 32'h2000);
    check("warn flag", {31'h0, warn_flag_o}, 32'h1);
    wr_st("range ok", 8'h11, 32'h20, 2'b10);
    move(6'h02);
    check("warn clr", {15'h0, warn_flag_o, warnings_o}, 32'h0);
    @(posedge clk_i);
    scaling_en_i <= 1'b0;
    units_per_turn_i <= CPT;
    i_esp_ctrl_model.new_range(TOT, 32'h0);
    rd_chk("state unscaled", 8'h29, 32'h2, 32'h0);
  endtask

  task automatic t_dir();
    move(6'h03);
    rd_chk("dir up", 8'h29, 32'h1, 32'h0);
    move(6'h01);
    rd_chk("dir down", 8'h29, 32'h1, 32'h1);
    @(posedge clk_i);
    count_ccw_i <= 1'b1;
    move(6'h04);
    rd_chk("dir ccw", 8'h29, 32'h1, 32'h1);
    @(posedge clk_i);
    count_ccw_i <= 1'b0;
    move(6'h05);
    rd_chk("dir cw", 8'h29, 32'h1, 32'h0);
  endtask

  // Ten counts per speed period in every unit, then reversed
  task automatic t_speed();
    step_on <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      wr_st("unit sel", 8'h19, {16'h0, codes[i]}, 2'b10);
      repeat (110) @(posedge clk_i);
      rd_chk("speed", 8'h18, ALL, speeds[i]);
    end
    wr_st("unit sel", 8'h19, 32'h1F04, 2'b10);
    step_dn <= 1'b1;
    repeat (110) @(posedge clk_i);
    rd_chk("speed neg", 8'h18, ALL, 32'hFFFF_FF9C);
    step_on <= 1'b0;
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Watchdog: the whole sequence needs under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    give_verdict();
  end

  // Main sequence
  initial begin
    err_total = 0;
    checks_done = 0;
    rst_i = 1'b1;
    scaling_en_i = 1'b0;
    count_ccw_i = 1'b0;
    preset_cmd_i = 1'b0;
    units_per_turn_i = CPT;
    shaft_pos_i = 6'h00;
    step_on = 1'b0;
    step_dn = 1'b0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_range();
    t_units();
    t_preset();
    t_scale();
    t_dir();
    t_speed();
    give_verdict();
  end
endmodule // tb_top
